//--- pixel_alu_ctrl_defines.vh
/*
 constants for the pixel ALU compare, scroll and blend control block:
 register offsets, reset values, field positions and pipeline timing.
 assumes inclusion by bare name from the design file.
*/
`ifndef PIXEL_ALU_CTRL_DEFINES_VH
`define PIXEL_ALU_CTRL_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets (APB word aligned)
// ----------------------------------------------------------------
`define OFS_COMPARE_CONTROL 6'h00
`define OFS_WRITE_ADDR_SEL 6'h04
`define OFS_SECOND_BLEND 6'h08
`define OFS_PICK_STATUS 6'h0C

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_COMPARE_CONTROL 32'h0A000000
`define RST_WRITE_ADDR_SEL 32'h00000000
`define RST_SECOND_BLEND 32'h00000000

// ----------------------------------------------------------------
// compare control fields
// ----------------------------------------------------------------
`define CC_PICK_CMD 27
`define CC_PICK_VAL 26
`define CC_HIT_CMD 25
`define CC_HIT_VAL 24
`define CC_MAG_SRC 17
`define CC_MATCH_SRC 16
`define CC_MATCH_HI 9
`define CC_MATCH_LO 8
`define CC_MAG_HI 2
`define CC_MAG_LO 0
// writable bits of compare control
`define CC_WMASK 32'h0F030307

// ----------------------------------------------------------------
// write address select and blend fields
// ----------------------------------------------------------------
`define WA_SEL_BIT 0
`define WA_DATA_HI 29
`define WA_DATA_LO 24
`define SB_SAT_HI 29
`define SB_SAT_LO 28
`define SB_WMASK 32'h3F0F0F0F
`define RB_BLEND3_BIT 28
`define FRACTION_ONE 9'h100
`define TOP_BYTE_HI 31
`define TOP_BYTE_LO 24
`define TOP_UNIT 3

// ----------------------------------------------------------------
// timing: write lands seven cycles after the write address
// ----------------------------------------------------------------
`define SCROLL_WR_DELAY 7

`endif

//--- pixel_compare_scroll_blend_ctrl.v
/*
 compare, scroll write-address and second blend control of a pixel ALU,
 with an APB slave for its three control registers and a status word.
 assumes the rendering controller drives the ALU port on clk, so those
 inputs need no synchroniser; apb signals are on clk as well.
*/
`timescale 1ns/1ps
`include "pixel_alu_ctrl_defines.vh"

module pixel_compare_scroll_blend_ctrl #(
   parameter WR_DELAY = `SCROLL_WR_DELAY
) (
   input wire clk,
   input wire resetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [5:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire statefulWr,
   input wire statelessWr,
   input wire passIn,
   input wire [5:0] aluAddressPins,
   input wire [31:0] aluDataPins,
   input wire [3:0] aluDataExt,
   input wire [31:0] constSource,
   input wire [3:0] constSourceExt,
   input wire [31:0] oldPixel,
   input wire [31:0] rasterBlendControl,
   output reg passOut,
   output reg hitPinOut,
   output reg hitPinOe,
   output reg pixelWrEn,
   output reg [5:0] pixelWrAddr,
   output reg [35:0] firstMultiplicand,
   output reg [31:0] secondMultiplicand,
   output reg [31:0] blendSumInput,
   output reg [7:0] alphaSatOut
);

   // ----------------------------------------------------------------
   // decode functions
   // ----------------------------------------------------------------
   // match test on equality or inequality
   // codes 0 and 1 ignore the data words
   function matchTest;
      input [1:0] sel;
      input [31:0] a;
      input [31:0] b;
      begin
         case (sel)
            2'h0: matchTest = 1'b1;
            2'h1: matchTest = 1'b0;
            2'h2: matchTest = (a == b);
            default: matchTest = (a != b);
         endcase
      end
   endfunction

   // magnitude test, incoming a against stored b
   // words compare as unsigned 32-bit values
   function magTest;
      input [2:0] sel;
      input [31:0] a;
      input [31:0] b;
      begin
         case (sel)
            3'h0: magTest = 1'b1;
            3'h1: magTest = (a > b);
            3'h2: magTest = (a == b);
            3'h3: magTest = (a >= b);
            3'h4: magTest = 1'b0;
            3'h5: magTest = (a <= b);
            3'h6: magTest = (a != b);
            default: magTest = (a < b);
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------
   reg [31:0] compareControl_r; // stored compare control
   reg [31:0] writeAddrSel_r; // stored write address select
   reg [31:0] secondBlend_r; // stored second blend control
   reg pickEnable_r; // picking enabled
   reg hit_r; // sticky pick hit flag
   reg scrollPend_r; // data write (stateful or stateless) waiting for its write address
   reg scrollGate_r; // its commit decision
   reg scrollSel_r; // its address source
   reg [5:0] scrollAddr_r; // its address from the address pins
   // the delay lines hold one stage fewer than the delay,
   // because the output registers form the last stage
   reg [WR_DELAY-2:0] pipeEn_r; // commit delay line
   reg [6*WR_DELAY-7:0] pipeAddr_r; // address delay line

   wire anyWr; // any data write this cycle
   wire apbWr; // write taken at access edge
   wire [31:0] effCompare; // compare control as the compare unit sees it
   wire [31:0] effBlend; // second blend as the blend units see it
   wire effAddrSel; // write address select as seen by this write
   wire [31:0] matchSrc; // match compare incoming value
   wire [31:0] magSrc; // magnitude compare incoming value
   wire matchPass; // match test result
   wire magPass; // magnitude test result
   wire bothPass; // both tests pass
   wire commit; // data write reaches the pixel buffer
   wire hitEvent; // picked write hits
   wire [5:0] wrAddrNow; // write address resolved one cycle after write
   wire [7:0] alphaSat; // alpha-saturate block output
   wire [7:0] oldTop; // stored top byte
   wire [7:0] newTop; // incoming top byte
   wire [7:0] satMin; // minimum of incoming and inverted stored
   wire [35:0] firstMultNxt; // per unit first multiplicands
   wire [31:0] secondMultNxt; // per unit second multiplicands
   wire [31:0] addendNxt; // per unit addends

   assign anyWr = statefulWr | statelessWr;
   assign apbWr = psel & penable & pwrite & pready;

   // ----------------------------------------------------------------
   // dual compare unit
   // ----------------------------------------------------------------
   // stateless writes see zeroed controls
   assign effCompare = statelessWr ? 32'h00000000 : compareControl_r;
   assign effBlend = statelessWr ? 32'h00000000 : secondBlend_r;
   assign effAddrSel = statelessWr ? 1'b0 : writeAddrSel_r[`WA_SEL_BIT];

   // match source by bit 16, magnitude by 17 xor 16
   // a select of one takes the constant source
   assign matchSrc = effCompare[`CC_MATCH_SRC] ? constSource : aluDataPins;
   assign magSrc = (effCompare[`CC_MAG_SRC] ^ effCompare[`CC_MATCH_SRC]) ? constSource : aluDataPins;

   assign matchPass = matchTest(effCompare[`CC_MATCH_HI:`CC_MATCH_LO], matchSrc, oldPixel);
   assign magPass = magTest(effCompare[`CC_MAG_HI:`CC_MAG_LO], magSrc, oldPixel);
   assign bothPass = matchPass & magPass;
   // stateful commits need the external pass too; stateless always commit
   assign commit = statelessWr | (statefulWr & bothPass & passIn);
   // a hit needs picking, a stateful write, both tests and pass
   assign hitEvent = pickEnable_r & statefulWr & bothPass & passIn;

   // ----------------------------------------------------------------
   // write address resolution
   // ----------------------------------------------------------------
   // scroll takes the write address from data pins one cycle later
   // a select of zero keeps the address pins captured with the write
   assign wrAddrNow = scrollSel_r ? aluDataPins[`WA_DATA_HI:`WA_DATA_LO] : scrollAddr_r;

   // ----------------------------------------------------------------
   // blend source selection
   // ----------------------------------------------------------------
   // top bytes feed the alpha-saturate block
   assign oldTop = oldPixel[`TOP_BYTE_HI:`TOP_BYTE_LO];
   assign newTop = aluDataPins[`TOP_BYTE_HI:`TOP_BYTE_LO];
   assign satMin = (newTop < ~oldTop) ? newTop : ~oldTop;
   // unit 3 out of blend mode forces stored top byte
   assign alphaSat = !rasterBlendControl[`RB_BLEND3_BIT] ? oldTop :
                     (effBlend[`SB_SAT_HI:`SB_SAT_LO] == 2'h0) ? satMin :
                     (effBlend[`SB_SAT_HI:`SB_SAT_LO] == 2'h1) ? newTop :
                     (effBlend[`SB_SAT_HI:`SB_SAT_LO] == 2'h2) ? oldTop : ~oldTop;

   genvar n;
   generate
      for (n = 0; n < 4; n = n + 1) begin : unitSel
         wire [7:0] oldB; // stored byte n
         wire [7:0] dqB; // incoming byte n
         wire [7:0] kB; // constant byte n
         wire [3:0] nib; // this unit's control nibble
         wire [1:0] frac; // fraction source field
         reg [8:0] fracVal; // fraction source value
         assign oldB = oldPixel[8*n+7:8*n];
         assign dqB = aluDataPins[8*n+7:8*n];
         assign kB = constSource[8*n+7:8*n];
         assign nib = effBlend[8*n+3:8*n];
         assign frac = rasterBlendControl[8*n+7:8*n+6];
         // fraction source picked by raster/blend control
         // the top unit's extension bit travels with the top byte
         always @* begin
            case (frac)
               2'h0: fracVal = `FRACTION_ONE;
               2'h1: fracVal = {constSourceExt[n], kB};
               2'h2: fracVal = {aluDataExt[n], dqB};
               default: fracVal = {aluDataExt[`TOP_UNIT], aluDataPins[`TOP_BYTE_HI:`TOP_BYTE_LO]};
            endcase
         end
         assign firstMultNxt[9*n+8:9*n] = nib[1] ? {1'b0, oldB} : fracVal;
         assign secondMultNxt[8*n+7:8*n] = nib[3] ? alphaSat : (nib[2] ? ~oldB : oldB);
         assign addendNxt[8*n+7:8*n] = nib[0] ? oldB :
                                       (rasterBlendControl[8*n+5] ? kB : dqB);
      end
   endgenerate

   // ----------------------------------------------------------------
   // apb register file and pick flags
   // ----------------------------------------------------------------
   // writes, one-shot commands and flag updates
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         compareControl_r <= `RST_COMPARE_CONTROL;
         writeAddrSel_r <= `RST_WRITE_ADDR_SEL;
         secondBlend_r <= `RST_SECOND_BLEND;
         pickEnable_r <= 1'b0;
         hit_r <= 1'b0;
      end else if (ce) begin
         // command bits clear one clock after loading
         compareControl_r[`CC_PICK_CMD] <= 1'b0;
         compareControl_r[`CC_HIT_CMD] <= 1'b0;
         // pick enable follows its command pair
         if (compareControl_r[`CC_PICK_CMD]) begin
            pickEnable_r <= compareControl_r[`CC_PICK_VAL];
         end
         // hardware set wins over software clear
         if (hitEvent) begin
            hit_r <= 1'b1;
         end else if (compareControl_r[`CC_HIT_CMD]) begin
            hit_r <= compareControl_r[`CC_HIT_VAL];
         end
         // reserved bits are dropped by the write masks
         if (apbWr) begin
            case (paddr)
               `OFS_COMPARE_CONTROL: compareControl_r <= pwdata & `CC_WMASK;
               `OFS_WRITE_ADDR_SEL: writeAddrSel_r <= {31'h00000000, pwdata[`WA_SEL_BIT]};
               `OFS_SECOND_BLEND: secondBlend_r <= pwdata & `SB_WMASK;
               default: ;
            endcase
         end
      end
   end

   // setup phase decode, answer in the access phase
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         // ready rises in the access cycle, with no wait states
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         // unmapped offsets answer with an error and zero data
         if (psel & ~penable) begin
            case (paddr)
               `OFS_COMPARE_CONTROL: prdata <= compareControl_r;
               `OFS_WRITE_ADDR_SEL: prdata <= writeAddrSel_r;
               `OFS_SECOND_BLEND: prdata <= secondBlend_r;
               `OFS_PICK_STATUS: prdata <= {30'h00000000, pickEnable_r, hit_r};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // scroll write pipeline
   // ----------------------------------------------------------------
   // hold the write one cycle, then delay it to the buffer
   // the write address is resolved in the cycle after the write,
   // enters the delay line at that edge and leaves the output
   // registers WR_DELAY cycles after the address cycle
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scrollPend_r <= 1'b0;
         scrollGate_r <= 1'b0;
         scrollSel_r <= 1'b0;
         scrollAddr_r <= 6'h00;
         pipeEn_r <= {(WR_DELAY-1){1'b0}};
         pipeAddr_r <= {(6*WR_DELAY-6){1'b0}};
      end else if (ce) begin
         scrollPend_r <= anyWr;
         scrollGate_r <= commit;
         scrollSel_r <= effAddrSel;
         scrollAddr_r <= aluAddressPins;
         // delay stages after the write address cycle, output register last
         pipeEn_r <= {pipeEn_r[WR_DELAY-3:0], scrollPend_r & scrollGate_r};
         pipeAddr_r <= {pipeAddr_r[6*WR_DELAY-13:0], wrAddrNow};
      end
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   // pass, hit pin and blend selections
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         passOut <= 1'b0;
         hitPinOut <= 1'b0;
         hitPinOe <= 1'b0;
         pixelWrEn <= 1'b0;
         pixelWrAddr <= 6'h00;
         firstMultiplicand <= 36'h000000000;
         secondMultiplicand <= 32'h00000000;
         blendSumInput <= 32'h00000000;
         alphaSatOut <= 8'h00;
      end else if (ce) begin
         // pass ignores the external pass input
         if (anyWr) begin
            passOut <= bothPass;
         end
         // hit pin data stays low; only its enable moves
         hitPinOut <= 1'b0;
         // drive low while the hit flag holds one
         hitPinOe <= hitEvent | (hit_r & ~(compareControl_r[`CC_HIT_CMD] & ~compareControl_r[`CC_HIT_VAL]))
                     | (compareControl_r[`CC_HIT_CMD] & compareControl_r[`CC_HIT_VAL]);
         // tail of the delay line to the pixel buffer
         pixelWrEn <= pipeEn_r[WR_DELAY-2];
         pixelWrAddr <= pipeAddr_r[6*WR_DELAY-7:6*WR_DELAY-12];
         // blend selections follow the inputs one cycle later
         firstMultiplicand <= firstMultNxt;
         secondMultiplicand <= secondMultNxt;
         blendSumInput <= addendNxt;
         alphaSatOut <= alphaSat;
      end
   end

endmodule

//--- pixel_alu_ctrl_chk.sv
/*
 checker for the pixel ALU compare, scroll and blend control block.
 assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module pixel_alu_ctrl_chk #(
   parameter WR_DELAY = 7
) (
   input wire clk,
   input wire resetn,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pwrite,
   input wire [5:0] paddr,
   input wire [31:0] pwdata,
   input wire statefulWr,
   input wire statelessWr,
   input wire passIn,
   input wire passOut,
   input wire hitPinOut,
   input wire hitPinOe,
   input wire pixelWrEn
);
   // ----------------------------------------------------------------
   // helper terms
   // ----------------------------------------------------------------
   localparam int WRD = WR_DELAY; // address-to-write delay
   localparam int LAT = WR_DELAY + 1; // data write to pixel write
   wire ccWr = psel && penable && pready && pwrite && paddr == 6'h00; // compare control write
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   commit_block_a: assert property (statefulWr ##1 !passOut |-> ##WRD !pixelWrEn)
      else $error("pixel write after failed compare");
   commit_pass_a: assert property ((statefulWr && passIn) ##1 passOut |-> ##WRD pixelWrEn)
      else $error("passing write not committed");
   stateless_pass_a: assert property (statelessWr |=> passOut)
      else $error("stateless write did not pass compare");
   stateless_commit_a: assert property (statelessWr |-> ##LAT pixelWrEn)
      else $error("stateless write not committed");
   write_origin_a: assert property (pixelWrEn |-> $past(statefulWr || statelessWr, LAT))
      else $error("pixel write without data write");
   pass_hold_a: assert property (!(statefulWr || statelessWr) |=> $stable(passOut))
      else $error("pass output moved without a write");
   hit_clear_a: assert property ($fell(hitPinOe) |-> $past(ccWr && pwdata[25:24] == 2'h2, 2))
      else $error("hit flag dropped without clear command");
   hit_rise_a: assert property ($rose(hitPinOe) |->
      $past(statefulWr && passIn) || $past(ccWr && pwdata[25:24] == 2'h3, 2))
      else $error("hit flag set without cause");
   hit_data_a: assert property (hitPinOut == 1'h0)
      else $error("open-drain hit pin driven high");
endmodule

//--- render_ctrl_model.sv
/*
 rendering controller model: issues data writes on the ALU port.
 assumes the bench supplies clk and calls dataWrite after a clock edge.
*/
`timescale 1ns/1ps
module render_ctrl_model (
   input wire logic clk,
   output logic statefulWr,
   output logic statelessWr,
   output logic passIn,
   output logic [5:0] aluAddressPins,
   output logic [31:0] aluDataPins,
   output logic [31:0] oldPixel
);
   // ----------------------------------------------------------------
   // one data write, scroll address on the next cycle
   // ----------------------------------------------------------------
   task dataWrite(input logic sl, input logic pi, input logic [5:0] ra,
                  input logic [31:0] nw, input logic [31:0] od, input logic [5:0] wa);
      @(posedge clk);
      statefulWr <= !sl;
      statelessWr <= sl;
      passIn <= pi;
      aluAddressPins <= ra;
      aluDataPins <= nw;
      oldPixel <= od;
      @(posedge clk);
      // strobes drop; released lines show inverted values
      statefulWr <= 1'h0;
      statelessWr <= 1'h0;
      passIn <= !pi;
      aluAddressPins <= ~ra;
      oldPixel <= ~od;
      aluDataPins <= {~nw[31:30], wa, ~nw[23:0]};
   endtask
   initial begin
      statefulWr = 1'h0;
      statelessWr = 1'h0;
      passIn = 1'h0;
      aluAddressPins = 6'h00;
      aluDataPins = 32'h00000000;
      oldPixel = 32'h00000000;
   end
endmodule

//--- tb_pixel_compare_scroll_blend_ctrl.sv
/*
 bench for the pixel ALU control block: APB master tasks and data writes.
 assumes the design, the controller model and the checker are compiled first.
*/
`timescale 1ns/1ps
module tb_pixel_compare_scroll_blend_ctrl;
   localparam logic [11:0] MATCH = 12'hA87; // pass pattern per match code
   localparam logic [23:0] MAG = 24'h358CA7; // pass pattern per magnitude code
   localparam logic [31:0] NW = 32'h9C5A3C11; // incoming pixel
   localparam logic [31:0] OD = 32'h6B2D8E47; // stored pixel
   logic clk, resetn, ce, psel, penable, pwrite, pready, pslverr, rdErr, pi, ex;
   logic [5:0] paddr, pixelWrAddr, lastAddr;
   logic [31:0] pwdata, prdata, rd, constSource, rasterBlendControl, secondMultiplicand, blendSumInput;
   logic [3:0] aluDataExt, constSourceExt;
   logic [35:0] firstMultiplicand;
   logic [7:0] alphaSatOut, sat;
   wire statefulWr, statelessWr, passIn, passOut, hitPinOut, hitPinOe, pixelWrEn;
   wire [5:0] aluAddressPins;
   wire [31:0] aluDataPins, oldPixel;
   int errCount, checks, wrCnt, c0, m, g, r, s;
   // ----------------------------------------------------------------
   // design and far side
   // ----------------------------------------------------------------
   pixel_compare_scroll_blend_ctrl #(.WR_DELAY(7)) dut_u (.clk(clk), .resetn(resetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .statefulWr(statefulWr),
      .statelessWr(statelessWr), .passIn(passIn), .aluAddressPins(aluAddressPins),
      .aluDataPins(aluDataPins), .aluDataExt(aluDataExt), .constSource(constSource),
      .constSourceExt(constSourceExt), .oldPixel(oldPixel), .rasterBlendControl(rasterBlendControl),
      .passOut(passOut), .hitPinOut(hitPinOut), .hitPinOe(hitPinOe), .pixelWrEn(pixelWrEn),
      .pixelWrAddr(pixelWrAddr), .firstMultiplicand(firstMultiplicand),
      .secondMultiplicand(secondMultiplicand), .blendSumInput(blendSumInput), .alphaSatOut(alphaSatOut));
   render_ctrl_model m_u (.clk(clk), .statefulWr(statefulWr), .statelessWr(statelessWr),
      .passIn(passIn), .aluAddressPins(aluAddressPins), .aluDataPins(aluDataPins), .oldPixel(oldPixel));
   always #2.5 clk = ~clk;
   // counts pixel writes and keeps the last write address
   always @(posedge clk) begin
      if (pixelWrEn === 1'h1) begin
         wrCnt++;
         lastAddr = pixelWrAddr;
      end
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task stopTest;
      if (errCount == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task cmp(input logic [35:0] got, input logic [35:0] exp);
      checks++;
      if (got !== exp) begin
         errCount++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one APB transfer, held until pready is sampled high
   task apb(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      // waits for ready; only the watchdog ends a hung wait
      do begin
         @(posedge clk);
      end while (pready !== 1'h1);
      rd = prdata;
      rdErr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task rdc(input logic [5:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h00000000);
      cmp(rd, e);
   endtask
   task dw(input logic sl, input logic p, input logic [5:0] ra, input logic [31:0] nw,
           input logic [31:0] od, input logic [5:0] wa);
      c0 = wrCnt;
      m_u.dataWrite(sl, p, ra, nw, od, wa);
      #1;
   endtask
   task settle;
      repeat (9) @(posedge clk);
      #1;
   endtask
   task cmdWait(input logic [31:0] d);
      apb(1'h1, 6'h00, d);
      repeat (2) @(posedge clk);
      #1;
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      clk = 1'h0; resetn = 1'h0; ce = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
      paddr = 6'h00; pwdata = 32'h00000000; aluDataExt = 4'h0; constSourceExt = 4'h0;
      constSource = 32'h5A5A5A5A; rasterBlendControl = 32'h03030303; errCount = 0; checks = 0; wrCnt = 0;
      repeat (6) @(posedge clk);
      resetn <= 1'h1;
      rdc(6'h00, 32'h00000000);
      rdc(6'h0C, 32'h00000000);
      rdc(6'h04, 32'h00000000);
      rdc(6'h08, 32'h00000000);
      apb(1'h0, 6'h10, 32'h00000000);
      cmp(rdErr, 1'h1);
      apb(1'h1, 6'h08, 32'h3F0F0F0F);
      rdc(6'h08, 32'h3F0F0F0F);
      apb(1'h1, 6'h04, 32'hFFFFFFFF);
      rdc(6'h04, 32'h00000001);
      apb(1'h1, 6'h04, 32'h00000000);
      // every match and magnitude code against less, equal and greater
      for (m = 0; m < 4; m++) for (g = 0; g < 8; g++) begin
         apb(1'h1, 6'h00, {22'h0, m[1:0], 5'h00, g[2:0]});
         for (r = 0; r < 3; r++) begin
            ex = MATCH[m * 3 + r] & MAG[g * 3 + r];
            pi = m[0] ^ g[0] ^ r[0];
            dw(1'h0, pi, 6'h03, 32'h40000010 + r - 1, 32'h40000010, 6'h2A);
            cmp(passOut, ex);
            settle;
            cmp(wrCnt - c0, ex & pi);
         end
      end
      cmp(hitPinOe, 1'h0);
      // picking: enable, hit, sticky, clear, set, disable
      apb(1'h1, 6'h00, 32'h0C000100);
      rdc(6'h00, 32'h04000100);
      rdc(6'h0C, 32'h00000002);
      dw(1'h0, 1'h1, 6'h01, NW, NW, 6'h01);
      cmp(hitPinOe, 1'h0);
      apb(1'h1, 6'h00, 32'h00000000);
      dw(1'h0, 1'h0, 6'h01, NW, NW, 6'h01);
      cmp(hitPinOe, 1'h0);
      dw(1'h0, 1'h1, 6'h01, NW, NW, 6'h01);
      cmp(hitPinOe, 1'h1);
      cmp(hitPinOut, 1'h0);
      rdc(6'h0C, 32'h00000003);
      cmdWait(32'h01000100);
      dw(1'h0, 1'h1, 6'h01, NW, NW, 6'h01);
      cmp(hitPinOe, 1'h1);
      cmdWait(32'h02000000);
      cmp(hitPinOe, 1'h0);
      cmdWait(32'h03000000);
      cmp(hitPinOe, 1'h1);
      cmdWait(32'h0A000000);
      cmp(hitPinOe, 1'h0);
      rdc(6'h0C, 32'h00000000);
      // scroll move from read address to data-pin address
      rasterBlendControl <= 32'h05050505;
      apb(1'h1, 6'h04, 32'h00000001);
      dw(1'h0, 1'h1, 6'h03, NW, OD, 6'h2D);
      settle;
      cmp(lastAddr, 6'h2D);
      dw(1'h1, 1'h0, 6'h03, NW, OD, 6'h2D);
      settle;
      cmp(lastAddr, 6'h03);
      cmp(wrCnt - c0, 1);
      apb(1'h1, 6'h04, 32'h00000000);
      dw(1'h0, 1'h1, 6'h07, NW, OD, 6'h2D);
      settle;
      cmp(lastAddr, 6'h07);
      // blend sources with each alpha-saturate code
      rasterBlendControl <= 32'h10000000;
      for (s = 0; s < 4; s++) begin
         apb(1'h1, 6'h08, {2'h0, s[1:0], 28'hE080700});
         dw(1'h0, 1'h1, 6'h01, NW, OD, 6'h01);
         case (s)
            0: sat = (NW[31:24] < ~OD[31:24]) ? NW[31:24] : ~OD[31:24];
            1: sat = NW[31:24];
            2: sat = OD[31:24];
            default: sat = ~OD[31:24];
         endcase
         cmp(alphaSatOut, sat);
         cmp(secondMultiplicand, {sat, sat, ~OD[15:8], OD[7:0]});
         cmp(firstMultiplicand, {1'h0, OD[31:24], 9'h100, 1'h0, OD[15:8], 9'h100});
         cmp(blendSumInput, {NW[31:16], OD[15:8], NW[7:0]});
         settle;
      end
      dw(1'h1, 1'h0, 6'h01, NW, OD, 6'h01);
      cmp(secondMultiplicand, OD);
      cmp(firstMultiplicand, {4{9'h100}});
      cmp(blendSumInput, NW);
      settle;
      stopTest;
   end
   // cuts a hang short
   initial begin
      #100000;
      errCount++;
      stopTest;
   end
endmodule
bind pixel_compare_scroll_blend_ctrl pixel_alu_ctrl_chk #(.WR_DELAY(WR_DELAY)) chk_u (.clk(clk),
   .resetn(resetn), .psel(psel), .penable(penable), .pready(pready), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .statefulWr(statefulWr), .statelessWr(statelessWr), .passIn(passIn),
   .passOut(passOut), .hitPinOut(hitPinOut), .hitPinOe(hitPinOe), .pixelWrEn(pixelWrEn));
